// ---- hdl/txfsc_pkg.sv ----
package txfsc_pkg;
  // Register indices (word addresses)
  localparam logic [7:0] ADDR_FRAMES_128_TO_255   = 8'h37;
  localparam logic [7:0] ADDR_FRAMES_256_TO_511   = 8'h38;
  localparam logic [7:0] ADDR_FRAMES_512_TO_1023  = 8'h39;
  localparam logic [7:0] ADDR_FRAMES_1024_PLUS    = 8'h3a;
  localparam logic [7:0] ADDR_UNDERFLOW_ABORTS    = 8'h3b;
  localparam logic [7:0] ADDR_SINGLE_COLLISION    = 8'h3c;
  // Counter widths
  localparam int BIN_W  = 32;
  localparam int UFL_W  = 10;
  localparam int SCOL_W = 18;
  // Bin boundaries in bytes
  localparam logic [15:0] LEN_BIN0_MIN = 16'h0080;
  localparam logic [15:0] LEN_BIN1_MIN = 16'h0100;
  localparam logic [15:0] LEN_BIN2_MIN = 16'h0200;
  localparam logic [15:0] LEN_BIN3_MIN = 16'h0400;
  // Reset value of all counters
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  // Saturation ceilings, one per counter width
  localparam logic [31:0] BIN_MAX   = 32'hffff_ffff;
  localparam logic [9:0]  UFL_MAX   = 10'h3ff;
  localparam logic [17:0] SCOL_MAX  = 18'h3ffff;
endpackage

// ---- hdl/txfsc_counters.sv ----
`timescale 1ns/100ps
// Function
// - Count each good frame of 128 to 255 bytes in the small bin.
// - Count each good frame of 256 to 511 bytes in the medium bin.
// - Count each good frame of 512 to 1023 bytes in the large bin.
// - Count each good frame of 1024 bytes or more in the jumbo bin.
// - Size-bin counters saturate at all-ones and never wrap.
// - Reading a size-bin counter returns its count and clears it.
// - A 10-bit counter counts frames aborted by transmit buffer underflow.
// - Underflow aborts count only in cut-through mode, never in store-and-forward.
// - The underflow counter saturates at 10-bit all-ones and clears on read.
// - An 18-bit counter counts good frames sent after exactly one collision.
// - With PLCA enabled the single-collision counter counts logical collisions.
// - The single-collision counter saturates at 18-bit all-ones, clears on read.
// - Unused upper bits of the narrow counters read as zero.
// - Binning length spans destination address through FCS, padding included.
module txfsc_counters (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        TX_DONE,
  input  wire logic        TX_OK,
  input  wire logic [15:0] TX_LEN,
  input  wire logic        TX_UNDERFLOW,
  input  wire logic        CUT_THROUGH,
  input  wire logic        PHY_SINGLE_COL,
  input  wire logic        PLCA_SINGLE_COL,
  input  wire logic        PLCA_ENABLE,
  input  wire logic        RD_EN,
  input  wire logic [7:0]  RD_ADDR,
  output logic [31:0]      RD_DATA,
  output logic             RD_VALID
);

  //////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [3:0][31:0] bin;
    logic [9:0]       ufl;
    logic [17:0]      scol;
    logic [31:0]      rdata;
    logic             rvalid;
  } txfsc_state_t;

  txfsc_state_t st;
  txfsc_state_t next_st;

  logic [3:0] bin_hit;
  logic [3:0] bin_rd;
  logic       ufl_inc;
  logic       scol_inc;
  logic       good;
  logic       col_one;

  //////////////////////////////////////////////////////////////////////////
  // Event decode
  // TX_LEN is the MAC's DA-to-FCS count with pad, so no adjustment here
  always_comb begin
    good = TX_DONE & TX_OK;
    bin_hit[0] = good && TX_LEN >= txfsc_pkg::LEN_BIN0_MIN
                 && TX_LEN < txfsc_pkg::LEN_BIN1_MIN;
    bin_hit[1] = good && TX_LEN >= txfsc_pkg::LEN_BIN1_MIN
                 && TX_LEN < txfsc_pkg::LEN_BIN2_MIN;
    bin_hit[2] = good && TX_LEN >= txfsc_pkg::LEN_BIN2_MIN
                 && TX_LEN < txfsc_pkg::LEN_BIN3_MIN;
    bin_hit[3] = good && TX_LEN >= txfsc_pkg::LEN_BIN3_MIN;
    // Store-and-forward cannot starve mid-frame, so gate with the mode
    ufl_inc  = TX_DONE & TX_UNDERFLOW & CUT_THROUGH;
    col_one  = PLCA_ENABLE ? PLCA_SINGLE_COL : PHY_SINGLE_COL;
    scol_inc = good & col_one;
    bin_rd[0] = RD_EN && RD_ADDR == txfsc_pkg::ADDR_FRAMES_128_TO_255;
    bin_rd[1] = RD_EN && RD_ADDR == txfsc_pkg::ADDR_FRAMES_256_TO_511;
    bin_rd[2] = RD_EN && RD_ADDR == txfsc_pkg::ADDR_FRAMES_512_TO_1023;
    bin_rd[3] = RD_EN && RD_ADDR == txfsc_pkg::ADDR_FRAMES_1024_PLUS;
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state: read clears, event in the same cycle as the read leaves one
  always_comb begin
    next_st = st;
    next_st.rvalid = RD_EN;
    next_st.rdata  = txfsc_pkg::CNT_RESET;
    for (int i = 0; i < 4; i++) begin
      if (bin_rd[i]) begin
        next_st.rdata  = st.bin[i];
        next_st.bin[i] = {31'h0, bin_hit[i]};
      end else if (bin_hit[i] && st.bin[i] != txfsc_pkg::BIN_MAX) begin
        next_st.bin[i] = st.bin[i] + 32'h1;
      end
    end
    if (RD_EN && RD_ADDR == txfsc_pkg::ADDR_UNDERFLOW_ABORTS) begin
      next_st.rdata = {22'h0, st.ufl};
      next_st.ufl   = {9'h0, ufl_inc};
    end else if (ufl_inc && st.ufl != txfsc_pkg::UFL_MAX) begin
      next_st.ufl = st.ufl + 10'h1;
    end
    if (RD_EN && RD_ADDR == txfsc_pkg::ADDR_SINGLE_COLLISION) begin
      next_st.rdata = {14'h0, st.scol};
      next_st.scol  = {17'h0, scol_inc};
    end else if (scol_inc && st.scol != txfsc_pkg::SCOL_MAX) begin
      next_st.scol = st.scol + 18'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign RD_DATA  = st.rdata;
  assign RD_VALID = st.rvalid;

endmodule

// ---- verif/txfsc_chk_sva.sv ----
`timescale 1ns/100ps
module txfsc_chk (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        TX_DONE,
  input wire logic        TX_OK,
  input wire logic [15:0] TX_LEN,
  input wire logic        RD_EN,
  input wire logic [7:0]  RD_ADDR,
  input wire logic [31:0] RD_DATA,
  input wire logic        RD_VALID
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // Small-bin good frame and read of that bin
  wire logic sm = TX_DONE && TX_OK && TX_LEN inside {[16'h0080:16'h00ff]};
  wire logic r7 = RD_EN && RD_ADDR == 8'h37;
  chk_valid_pulse: assert property (RD_EN |=> RD_VALID) else $error("valid missing");
  chk_idle_quiet: assert property (!RD_EN |=> !RD_VALID && RD_DATA == 0) else $error("idle out");
  chk_ufl_upper: assert property (RD_EN && RD_ADDR == 8'h3b |=> RD_DATA[31:10] == 0)
    else $error("underflow upper bits");
  chk_scol_upper: assert property (RD_EN && RD_ADDR == 8'h3c |=> RD_DATA[31:18] == 0)
    else $error("collision upper bits");
  chk_unmapped_zero: assert property (RD_EN && !(RD_ADDR inside {[8'h37:8'h3c]}) |=> RD_DATA == 0)
    else $error("unmapped data");
  chk_clear_read: assert property (r7 && !TX_DONE ##1 !TX_DONE ##1 r7 && !TX_DONE |=> RD_DATA == 0)
    else $error("no clear on read");
  chk_coincide_one: assert property (sm && r7 ##1 !TX_DONE ##1 r7 |=> RD_DATA == 1)
    else $error("event lost at clear");
  chk_small_count: assert property (r7 && !TX_DONE ##1 !TX_DONE ##1 sm ##1 !TX_DONE ##1 r7
    |=> RD_DATA == 1) else $error("small bin count");
  cover property (sm && r7);
  cover property (RD_EN && RD_ADDR == 8'h3b);
  cover property (TX_DONE && !TX_OK);
endmodule

// ---- verif/tb_tx_frame_statistics_counters.sv ----
`timescale 1ns/100ps
module tb_tx_frame_statistics_counters;
  logic        MCLK = 0, RESETN = 0, TX_DONE = 0, TX_OK = 0, TX_UNDERFLOW = 0, RD_EN = 0;
  logic        CUT_THROUGH = 0, PHY_SINGLE_COL = 0, PLCA_SINGLE_COL = 0, PLCA_ENABLE = 0;
  logic        RD_VALID;
  logic [15:0] TX_LEN = 0;
  logic [7:0]  RD_ADDR = 0;
  logic [31:0] RD_DATA;
  logic [15:0] lens[9] = '{16'h7f, 16'h80, 16'hff, 16'h100, 16'h1ff, 16'h200, 16'h3ff, 16'h400, 16'hffff};
  logic [5:0]  cf[5] = '{6'h24, 6'h22, 6'h23, 6'h25, 6'h04};
  int          bad_count = 0, checks_done = 0, cyc = 0;
  txfsc_counters u_dut (.*);
  always #10 MCLK = ~MCLK;
  // Hang guard: whole run is about 2140 cycles
  always @(posedge MCLK) if (++cyc == 6000) begin bad_count++; wrap_up; end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Flags: ok, underflow, cut-through, phy col, plca col, plca enable
  task automatic ev(input logic [15:0] l, input logic [5:0] f);
    @(negedge MCLK);
    {TX_OK, TX_UNDERFLOW, CUT_THROUGH, PHY_SINGLE_COL, PLCA_SINGLE_COL, PLCA_ENABLE} = f;
    TX_LEN = l;
    TX_DONE = 1;
    @(negedge MCLK);
    TX_DONE = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge MCLK);
    RD_EN = 1;
    RD_ADDR = a;
    @(negedge MCLK);
    RD_EN = 0;
    checks_done++;
    if (RD_VALID !== 1'b1 || RD_DATA !== e) begin
      bad_count++;
      $display("[ERR] reg %h expected %h seen %h", a, e, RD_DATA);
    end
  endtask
  initial begin
    repeat (4) @(negedge MCLK);
    RESETN = 1;
    for (int a = 'h37; a <= 'h3c; a++) rd(8'(a), 0);
    foreach (lens[i]) ev(lens[i], 6'h20);
    ev(16'hc8, 6'h00);
    for (int a = 'h37; a <= 'h3a; a++) rd(8'(a), 2);
    $display("test bins done");
    ev(16'h40, 6'h18);
    ev(16'h40, 6'h10);
    rd(8'h3b, 1);
    foreach (cf[i]) ev(16'h40, cf[i]);
    rd(8'h3c, 2);
    repeat (1030) ev(16'h40, 6'h18);
    rd(8'h3b, 32'h3ff);
    $display("test abort and collision done");
    fork ev(16'hc8, 6'h20); rd(8'h37, 0); join
    rd(8'h37, 1);
    ev(16'hc8, 6'h20);
    rd(8'h37, 1);
    rd(8'h37, 0);
    rd(8'h40, 0);
    $display("test clear done");
    wrap_up;
  end
endmodule
bind txfsc_counters txfsc_chk u_chk (.*);
